// ==== rtl/spr_route.sv ====
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "spr_regs.svh"

// Notes on behaviour
// - Main port data input gated by enable
// - Frame source: off, three pins, main
// - Bit clock source: off, pins, main
// - Input A: off, pins, data pin, main
// - Input B uses the same code set
// - Record channel one converter or microphone
// - Record channel two converter or microphone
// - Pair A edges: ch1 fall, ch2 rise
// - Pair B edges: ch3 fall, ch4 rise
// - Pair A data pin: off or pins
// - Pair B data pin: off or pins
// - Data pin carries microphone clock, code four
module spr_route
  import spr_pkg::*;
#(
  parameter int MIC_HALF = `SPR_MIC_HALF_CYC
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Pins
  input wire logic [2:0] MULTI_PIN_IN,
  input wire logic DOUT_PIN_IN,
  input wire logic MAIN_FRAME_IN,
  input wire logic MAIN_BITCLK_IN,
  input wire logic MAIN_DATA_IN,
  output logic DOUT_PIN_OUT,
  output logic DOUT_PIN_OE_OUT,
  // Main port
  output logic MAIN_DATA_OUT,
  // Second port
  output logic SEC_PORT_EN_OUT,
  output logic SEC_FRAME_OUT,
  output logic SEC_BITCLK_OUT,
  output logic SEC_DATA_A_OUT,
  output logic SEC_DATA_B_OUT,
  // Record path
  output logic REC_CH_ONE_TYPE_OUT,
  output logic REC_CH_TWO_TYPE_OUT,
  output logic [3:0] MIC_CH_DATA_OUT,
  output logic [3:0] MIC_CH_VALID_OUT
);

  if (MIC_HALF < 2 || MIC_HALF > 65535) begin : g_bad_half
    $error("MIC_HALF out of range");
  end

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [6:0] pins_s;
  logic [2:0] mp_s;
  logic dout_s;
  logic mframe_s;
  logic mbclk_s;
  logic mdata_s;

  spr_pin_sync #(
    .W(7)
  ) u_sync (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .pins_in({MAIN_DATA_IN, MAIN_BITCLK_IN, MAIN_FRAME_IN, DOUT_PIN_IN, MULTI_PIN_IN}),
    .pins_out(pins_s)
  );

  assign mp_s = pins_s[2:0];
  assign dout_s = pins_s[3];
  assign mframe_s = pins_s[4];
  assign mbclk_s = pins_s[5];
  assign mdata_s = pins_s[6];

  ////////////////////////////////////////////////////////////////////
  // Source selection

  function automatic logic spr_pick(
    input logic [2:0] code,
    input logic [2:0] mp,
    input logic dout,
    input logic main
  );
    logic r;
    r = 1'b0;
    case (code)
      SPR_SRC_PIN1: r = mp[0];
      SPR_SRC_PIN2: r = mp[1];
      SPR_SRC_PIN3: r = mp[2];
      SPR_SRC_DOUT: r = dout;
      SPR_SRC_MAIN: r = main;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : spr_pick

  // Clock and frame fields have no data pin code
  function automatic logic spr_clk_legal(input logic [2:0] code);
    logic r;
    r = 1'b0;
    case (code)
      SPR_SRC_PIN1, SPR_SRC_PIN2, SPR_SRC_PIN3, SPR_SRC_MAIN: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : spr_clk_legal

  ////////////////////////////////////////////////////////////////////
  // State

  spr_state_t q;
  spr_state_t n;

  logic [9:0] word;
  logic hit;
  logic wr_take;
  logic [31:0] rdata;
  logic [2:0] frame_code;
  logic [2:0] bitclk_code;
  logic [2:0] in_a_code;
  logic [2:0] in_b_code;
  logic [1:0] pair_a_src;
  logic [1:0] pair_b_src;
  logic tick;
  logic mic_rise;
  logic mic_fall;
  logic pair_a_bit;
  logic pair_b_bit;

  assign word = PADDR_IN[11:2];
  assign hit = (word == `SPR_IDX_CLK_FRAME) || (word == `SPR_IDX_DATA)
            || (word == `SPR_IDX_MIC) || (word == `SPR_IDX_PIN_FUNC)
            || (word == `SPR_IDX_STATUS);
  // Write lands only on the access edge, with pready already high
  assign wr_take = PSEL_IN && PENABLE_IN && PWRITE_IN && q.pready && hit;

  assign frame_code = q.cfg_clk_frame[`SPR_FRAME_LSB +: 3];
  assign bitclk_code = q.cfg_clk_frame[`SPR_BITCLK_LSB +: 3];
  assign in_a_code = q.cfg_data[`SPR_IN_A_LSB +: 3];
  assign in_b_code = q.cfg_data[`SPR_IN_B_LSB +: 3];
  assign pair_a_src = q.cfg_mic[`SPR_PAIR_A_SRC_LSB +: 2];
  assign pair_b_src = q.cfg_mic[`SPR_PAIR_B_SRC_LSB +: 2];

  // Microphone clock edges, known ahead since this block makes the clock
  assign tick = q.mic_run && (q.div_cnt == 16'(MIC_HALF - 1));
  assign mic_rise = tick && !q.mic_clk;
  assign mic_fall = tick && q.mic_clk;

  assign pair_a_bit = spr_pick({1'b0, pair_a_src}, mp_s, 1'b0, 1'b0);
  assign pair_b_bit = spr_pick({1'b0, pair_b_src}, mp_s, 1'b0, 1'b0);

  always_comb begin
    rdata = 32'h0000_0000;
    case (word)
      `SPR_IDX_CLK_FRAME: rdata[7:0] = q.cfg_clk_frame;
      `SPR_IDX_DATA: rdata[7:0] = q.cfg_data;
      `SPR_IDX_MIC: rdata[7:0] = q.cfg_mic;
      `SPR_IDX_PIN_FUNC: rdata[3:0] = q.cfg_pin_func;
      `SPR_IDX_STATUS: rdata[5:0] = {dout_s, mp_s, q.mic_run, q.sec_en};
      default: rdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = q;

    // Bus: answer prepared in setup, so access phase has no wait
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    if (PSEL_IN && !PENABLE_IN) begin
      n.pready = 1'b1;
      n.pslverr = !hit;
      n.prdata = PWRITE_IN ? 32'h0000_0000 : rdata;
    end

    // Reserved bits are masked so they always read zero
    if (wr_take) begin
      case (word)
        `SPR_IDX_CLK_FRAME: n.cfg_clk_frame = PWDATA_IN[7:0] & `SPR_MASK_CLK_FRAME;
        `SPR_IDX_DATA: n.cfg_data = PWDATA_IN[7:0] & `SPR_MASK_DATA;
        `SPR_IDX_MIC: n.cfg_mic = PWDATA_IN[7:0] & `SPR_MASK_MIC;
        `SPR_IDX_PIN_FUNC: n.cfg_pin_func = PWDATA_IN[3:0];
        default: n = n;
      endcase
    end

    // Routing follows stored fields, one cycle after the write
    n.main_in = q.cfg_clk_frame[`SPR_MAIN_EN_BIT] & mdata_s;
    n.sec_en = spr_clk_legal(frame_code) && spr_clk_legal(bitclk_code);
    n.sec_frame = n.sec_en ? spr_pick(frame_code, mp_s, 1'b0, mframe_s) : 1'b0;
    n.sec_bitclk = n.sec_en ? spr_pick(bitclk_code, mp_s, 1'b0, mbclk_s) : 1'b0;
    n.sec_in_a = spr_pick(in_a_code, mp_s, dout_s, mdata_s);
    n.sec_in_b = spr_pick(in_b_code, mp_s, dout_s, mdata_s);
    n.ch1_type = q.cfg_mic[`SPR_CH1_TYPE_BIT];
    n.ch2_type = q.cfg_mic[`SPR_CH2_TYPE_BIT];

    // Divider stops and parks low when no pair is routed
    n.mic_run = (pair_a_src != 2'h0) || (pair_b_src != 2'h0);
    if (!q.mic_run) begin
      n.div_cnt = 16'h0000;
      n.mic_clk = 1'b0;
    end else if (tick) begin
      n.div_cnt = 16'h0000;
      n.mic_clk = !q.mic_clk;
    end else begin
      n.div_cnt = q.div_cnt + 16'h0001;
    end

    n.pin_oe = (q.cfg_pin_func == SPR_FUNC_MIC_CLK);
    n.pin_mic = n.pin_oe && n.mic_clk;
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      q <= '0;
      q.cfg_clk_frame <= `SPR_RST_CLK_FRAME;
      q.cfg_data <= `SPR_RST_DATA;
      q.cfg_mic <= `SPR_RST_MIC;
      q.cfg_pin_func <= `SPR_RST_PIN_FUNC;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Microphone capture
  // Data is read after the synchroniser, so the bit taken at an edge
  // is the level from two cycles before it; fine at this clock ratio.

  logic [1:0] pair_on;
  logic [1:0] pair_swap;
  logic [1:0] pair_bit;

  // Both pairs share one clock, so only source and edge differ per pair
  assign pair_on[0] = (pair_a_src != 2'h0);
  assign pair_on[1] = (pair_b_src != 2'h0);
  assign pair_swap[0] = q.cfg_mic[`SPR_PAIR_A_EDGE_BIT];
  assign pair_swap[1] = q.cfg_mic[`SPR_PAIR_B_EDGE_BIT];
  assign pair_bit[0] = pair_a_bit;
  assign pair_bit[1] = pair_b_bit;

  for (genvar g = 0; g < 2; g++) begin : g_pair
    spr_mic_capture u_pair (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .enable_in(pair_on[g]),
      .swap_in(pair_swap[g]),
      .rise_in(mic_rise),
      .fall_in(mic_fall),
      .data_in(pair_bit[g]),
      .odd_out(MIC_CH_DATA_OUT[2 * g]),
      .even_out(MIC_CH_DATA_OUT[2 * g + 1]),
      .odd_valid_out(MIC_CH_VALID_OUT[2 * g]),
      .even_valid_out(MIC_CH_VALID_OUT[2 * g + 1])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign PRDATA_OUT = q.prdata;
  assign PREADY_OUT = q.pready;
  assign PSLVERR_OUT = q.pslverr;
  assign DOUT_PIN_OUT = q.pin_mic;
  assign DOUT_PIN_OE_OUT = q.pin_oe;
  assign MAIN_DATA_OUT = q.main_in;
  assign SEC_PORT_EN_OUT = q.sec_en;
  assign SEC_FRAME_OUT = q.sec_frame;
  assign SEC_BITCLK_OUT = q.sec_bitclk;
  assign SEC_DATA_A_OUT = q.sec_in_a;
  assign SEC_DATA_B_OUT = q.sec_in_b;
  assign REC_CH_ONE_TYPE_OUT = q.ch1_type;
  assign REC_CH_TWO_TYPE_OUT = q.ch2_type;

endmodule : spr_route

`default_nettype wire

// ==== pkg/spr_regs.svh ====
`ifndef SPR_REGS_SVH
`define SPR_REGS_SVH

// Register indices; byte address is four times the index
`define SPR_IDX_CLK_FRAME 10'h011
`define SPR_IDX_DATA 10'h012
`define SPR_IDX_MIC 10'h013
`define SPR_IDX_PIN_FUNC 10'h020
`define SPR_IDX_STATUS 10'h021

// Reset values
`define SPR_RST_CLK_FRAME 8'h80
`define SPR_RST_DATA 8'h00
`define SPR_RST_MIC 8'h00
`define SPR_RST_PIN_FUNC 4'h5

// Writable bits; reserved bits stay zero
`define SPR_MASK_CLK_FRAME 8'hFE
`define SPR_MASK_DATA 8'hFC
`define SPR_MASK_MIC 8'hFF

// Field positions
`define SPR_MAIN_EN_BIT 7
`define SPR_FRAME_LSB 4
`define SPR_BITCLK_LSB 1
`define SPR_IN_A_LSB 5
`define SPR_IN_B_LSB 2
`define SPR_CH1_TYPE_BIT 7
`define SPR_CH2_TYPE_BIT 6
`define SPR_PAIR_A_EDGE_BIT 5
`define SPR_PAIR_B_EDGE_BIT 4
`define SPR_PAIR_A_SRC_LSB 2
`define SPR_PAIR_B_SRC_LSB 0

// Timing
`define SPR_CLK_NS 10
`define SPR_MIC_CLK_NS 320
`define SPR_MIC_HALF_CYC (`SPR_MIC_CLK_NS / (2 * `SPR_CLK_NS))
`define SPR_DIV_W 16

`endif

// ==== pkg/spr_pkg.sv ====
package spr_pkg;

  // Source codes shared by the routing fields
  typedef enum logic [2:0] {
    SPR_SRC_OFF = 3'h0,
    SPR_SRC_PIN1 = 3'h1,
    SPR_SRC_PIN2 = 3'h2,
    SPR_SRC_PIN3 = 3'h3,
    SPR_SRC_DOUT = 3'h4,
    SPR_SRC_MAIN = 3'h5
  } spr_src_t;

  typedef enum logic [3:0] {
    SPR_FUNC_MIC_CLK = 4'h4
  } spr_pin_func_t;

  typedef struct packed {
    logic odd;
    logic even;
    logic odd_v;
    logic even_v;
  } spr_cap_t;

  typedef struct packed {
    logic [7:0] cfg_clk_frame;
    logic [7:0] cfg_data;
    logic [7:0] cfg_mic;
    logic [3:0] cfg_pin_func;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [15:0] div_cnt;
    logic mic_clk;
    logic mic_run;
    logic pin_mic;
    logic pin_oe;
    logic sec_en;
    logic sec_frame;
    logic sec_bitclk;
    logic sec_in_a;
    logic sec_in_b;
    logic main_in;
    logic ch1_type;
    logic ch2_type;
  } spr_state_t;

endpackage : spr_pkg

// ==== rtl/spr_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module spr_pin_sync #(
  parameter int W = 7
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Pins
  input wire logic [W-1:0] pins_in,
  output logic [W-1:0] pins_out
);

  if (W < 1) begin : g_bad_w
    $error("W must be at least one");
  end

  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } spr_sync_t;

  spr_sync_t q;
  spr_sync_t n;

  // First stage feeds only the second stage
  always_comb begin
    n.s1 = pins_in;
    n.s2 = q.s1;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign pins_out = q.s2;

endmodule : spr_pin_sync

`default_nettype wire

// ==== rtl/spr_mic_capture.sv ====
`timescale 1ns/1ps
`default_nettype none

module spr_mic_capture
  import spr_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic enable_in,
  input wire logic swap_in,
  input wire logic rise_in,
  input wire logic fall_in,
  input wire logic data_in,
  // Captured channels
  output logic odd_out,
  output logic even_out,
  output logic odd_valid_out,
  output logic even_valid_out
);

  spr_cap_t q;
  spr_cap_t n;

  always_comb begin
    logic odd_edge;
    logic even_edge;
    odd_edge = swap_in ? rise_in : fall_in;
    even_edge = swap_in ? fall_in : rise_in;
    n = q;
    n.odd_v = 1'b0;
    n.even_v = 1'b0;
    if (enable_in && odd_edge) begin
      n.odd = data_in;
      n.odd_v = 1'b1;
    end
    if (enable_in && even_edge) begin
      n.even = data_in;
      n.even_v = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign odd_out = q.odd;
  assign even_out = q.even;
  assign odd_valid_out = q.odd_v;
  assign even_valid_out = q.even_v;

endmodule : spr_mic_capture

`default_nettype wire

// ==== dv/spr_route_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "spr_regs.svh"
module spr_route_props (
  // Bus
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic PREADY_OUT,
  // Outputs
  input wire logic MAIN_DATA_OUT,
  input wire logic SEC_PORT_EN_OUT,
  input wire logic SEC_FRAME_OUT,
  input wire logic SEC_DATA_A_OUT,
  input wire logic SEC_DATA_B_OUT,
  input wire logic REC_CH_ONE_TYPE_OUT,
  input wire logic REC_CH_TWO_TYPE_OUT,
  input wire logic DOUT_PIN_OUT,
  input wire logic DOUT_PIN_OE_OUT,
  input wire logic [3:0] MIC_CH_VALID_OUT
);
  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);
  ////////////////////////////////////////
  // Shadow of the settings, loaded on the committing edge
  logic [7:0] cf_q;
  logic [7:0] dt_q;
  logic [7:0] mc_q;
  logic [3:0] pf_q;
  logic [9:0] ix;
  assign ix = PADDR_IN[11:2];
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      cf_q <= `SPR_RST_CLK_FRAME;
      dt_q <= `SPR_RST_DATA;
      mc_q <= `SPR_RST_MIC;
      pf_q <= `SPR_RST_PIN_FUNC;
    end else if (PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN) begin
      if (ix == `SPR_IDX_CLK_FRAME) cf_q <= PWDATA_IN[7:0];
      if (ix == `SPR_IDX_DATA) dt_q <= PWDATA_IN[7:0];
      if (ix == `SPR_IDX_MIC) mc_q <= PWDATA_IN[7:0];
      if (ix == `SPR_IDX_PIN_FUNC) pf_q <= PWDATA_IN[3:0];
    end
  end
  chk_main_gate: assert property (!cf_q[7] && !$past(cf_q[7]) |-> !MAIN_DATA_OUT)
    else $error("main data leaked");
  chk_frame_off: assert property (cf_q[6:4] == 3'h0 && $stable(cf_q)
    |-> !SEC_PORT_EN_OUT && !SEC_FRAME_OUT) else $error("frame not off");
  chk_bclk_off: assert property ((cf_q[3:1] inside {3'h0, 3'h4, 3'h6, 3'h7}) && $stable(cf_q)
    |-> !SEC_PORT_EN_OUT) else $error("port not off");
  chk_in_a_off: assert property ((dt_q[7:5] inside {3'h0, 3'h6, 3'h7}) && $stable(dt_q)
    |-> !SEC_DATA_A_OUT) else $error("input a not off");
  chk_in_b_off: assert property ((dt_q[4:2] inside {3'h0, 3'h6, 3'h7}) && $stable(dt_q)
    |-> !SEC_DATA_B_OUT) else $error("input b not off");
  chk_ch_one_type: assert property (REC_CH_ONE_TYPE_OUT == $past(mc_q[7]))
    else $error("type one wrong");
  chk_ch_two_type: assert property (REC_CH_TWO_TYPE_OUT == $past(mc_q[6]))
    else $error("type two wrong");
  chk_clock_pin: assert property ((DOUT_PIN_OE_OUT == ($past(pf_q) == 4'h4))
    && (DOUT_PIN_OE_OUT || !DOUT_PIN_OUT)) else $error("clock pin wrong");
  chk_pair_a_off: assert property ((mc_q[3:2] == 2'h0) [*4]
    |-> MIC_CH_VALID_OUT[1:0] == 2'h0) else $error("pair a captured");
  chk_pair_b_off: assert property ((mc_q[1:0] == 2'h0) [*4]
    |-> MIC_CH_VALID_OUT[3:2] == 2'h0) else $error("pair b captured");
  // Holds for any half period: valid and the pin level are registered on the same edge
  chk_pair_a_edge: assert property (MIC_CH_VALID_OUT[1] && DOUT_PIN_OE_OUT
    && mc_q == $past(mc_q, 3) |-> DOUT_PIN_OUT == !mc_q[5]) else $error("pair a edge");
endmodule : spr_route_props
bind spr_route spr_route_props chk_u (
  .CLK_IN(CLK_IN),
  .RST_IN(RST_IN),
  .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN),
  .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN),
  .PREADY_OUT(PREADY_OUT),
  .MAIN_DATA_OUT(MAIN_DATA_OUT),
  .SEC_PORT_EN_OUT(SEC_PORT_EN_OUT),
  .SEC_FRAME_OUT(SEC_FRAME_OUT),
  .SEC_DATA_A_OUT(SEC_DATA_A_OUT),
  .SEC_DATA_B_OUT(SEC_DATA_B_OUT),
  .REC_CH_ONE_TYPE_OUT(REC_CH_ONE_TYPE_OUT),
  .REC_CH_TWO_TYPE_OUT(REC_CH_TWO_TYPE_OUT),
  .DOUT_PIN_OUT(DOUT_PIN_OUT),
  .DOUT_PIN_OE_OUT(DOUT_PIN_OE_OUT),
  .MIC_CH_VALID_OUT(MIC_CH_VALID_OUT)
);
`default_nettype wire

// ==== dv/spr_mic_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module spr_mic_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Microphone side
  input wire logic mic_clk_in,
  input wire logic fall_bit_in,
  input wire logic rise_bit_in,
  output logic data_out
);
  logic clk_q;
  logic [3:0] idle_q;
  ////////////////////////////////////////
  // Bit for the falling edge is shown while the clock is high; a parked clock leaves
  // the line floating, shown as a toggling level so no stale bit passes for data
  always_ff @(posedge clk_in) begin
    clk_q <= mic_clk_in;
    if (rst_in) begin
      idle_q <= 4'hF;
    end else if (mic_clk_in != clk_q) begin
      idle_q <= 4'h0;
    end else if (idle_q != 4'hF) begin
      idle_q <= idle_q + 4'h1;
    end
    if (idle_q > 4'h8) data_out <= !data_out;
    else data_out <= mic_clk_in ? fall_bit_in : rise_bit_in;
  end
endmodule : spr_mic_model
`default_nettype wire

// ==== dv/spr_route_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module spr_route_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel = 1'b0;
  logic en = 1'b0;
  logic wrt = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wd = 32'h00000000;
  logic [31:0] rd;
  logic [31:0] got;
  logic rdy, err, gerr, dpo, doe, mo, se, sf, sb, sa, sbb, t1, t2, pe;
  logic [2:0] rp = 3'h0;
  logic [2:0] mp;
  logic [3:0] ps = 4'h0;
  logic [3:0] md, mv, seen;
  logic [1:0] mk;
  logic [1:0] fb = 2'h0;
  logic [1:0] rb = 2'h0;
  logic [1:0] fr;
  logic [7:0] cf, dt, mc;
  logic mm = 1'b0;
  int ia = 0;
  int ib = 1;
  int errors = 0;
  int tests_run = 0;
  int seed = 61743;
  // Shared pin level: the device drives it only while its enable is up
  wire logic dw = doe ? dpo : ps[3];
  always_comb begin
    mp = rp;
    if (mm) begin
      mp[ia] = mk[0];
      mp[ib] = mk[1];
    end
  end
  spr_route #(.MIC_HALF(4)) dut_u (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(sel),
    .PENABLE_IN(en), .PWRITE_IN(wrt), .PADDR_IN(adr), .PWDATA_IN(wd), .PRDATA_OUT(rd),
    .PREADY_OUT(rdy), .PSLVERR_OUT(err), .MULTI_PIN_IN(mp), .DOUT_PIN_IN(dw),
    .MAIN_FRAME_IN(ps[2]), .MAIN_BITCLK_IN(ps[1]), .MAIN_DATA_IN(ps[0]), .DOUT_PIN_OUT(dpo),
    .DOUT_PIN_OE_OUT(doe), .MAIN_DATA_OUT(mo), .SEC_PORT_EN_OUT(se), .SEC_FRAME_OUT(sf),
    .SEC_BITCLK_OUT(sb), .SEC_DATA_A_OUT(sa), .SEC_DATA_B_OUT(sbb), .REC_CH_ONE_TYPE_OUT(t1),
    .REC_CH_TWO_TYPE_OUT(t2), .MIC_CH_DATA_OUT(md), .MIC_CH_VALID_OUT(mv));
  spr_mic_model mic_a_u (.clk_in(clk), .rst_in(rst), .mic_clk_in(dw), .fall_bit_in(fb[0]),
    .rise_bit_in(rb[0]), .data_out(mk[0]));
  spr_mic_model mic_b_u (.clk_in(clk), .rst_in(rst), .mic_clk_in(dw), .fall_bit_in(fb[1]),
    .rise_bit_in(rb[1]), .data_out(mk[1]));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    sel <= 1'b1;
    wrt <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    en <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    got = rd;
    gerr = err;
    sel <= 1'b0;
    en <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, got, e);
  endtask : rchk
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  function automatic logic legal(input logic [2:0] c);
    legal = c inside {3'h1, 3'h2, 3'h3, 3'h5};
  endfunction : legal
  function automatic logic pick(input logic [2:0] c, input logic [2:0] p, input logic d,
    input logic m);
    case (c)
      3'h1, 3'h2, 3'h3: pick = p[c - 3'h1];
      3'h4: pick = d;
      3'h5: pick = m;
      default: pick = 1'b0;
    endcase
  endfunction : pick
  function automatic logic micexp(input int c);
    logic eb;
    eb = (c < 2) ? mc[5] : mc[4];
    micexp = (c[0] ^ eb) ? rb[c / 2] : fb[c / 2];
  endfunction : micexp
  ////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk("route_a", 12'h044, 32'h80);
    rchk("route_b", 12'h048, 32'h0);
    rchk("mic_cfg", 12'h04C, 32'h0);
    rchk("pin_func", 12'h080, 32'h5);
    // Reserved bits set on purpose: they must read back as zero
    apb(1'b1, 12'h044, 32'hFF);
    rchk("route_a", 12'h044, 32'hFE);
    apb(1'b1, 12'h048, 32'hFF);
    rchk("route_b", 12'h048, 32'hFC);
    apb(1'b0, 12'h050, 32'h0);
    chk("unmapped", {gerr, got[30:0]}, 32'h80000000);
    for (int i = 0; i < 64; i++) begin
      rp <= 3'($random(seed));
      ps <= 4'($random(seed));
      cf = {1'($random(seed)), 3'(i), 3'(i / 8), 1'b0};
      dt = {3'(i / 8), 3'(i), 2'h0};
      mc = {2'($random(seed)), 6'h00};
      apb(1'b1, 12'h044, {24'h0, cf});
      apb(1'b1, 12'h048, {24'h0, dt});
      apb(1'b1, 12'h04C, {24'h0, mc});
      repeat (4) @(posedge clk);
      pe = legal(cf[6:4]) && legal(cf[3:1]);
      chk("port_en", se, pe);
      chk("frame", sf, pe & pick(cf[6:4], rp, 1'b0, ps[2]));
      chk("bitclk", sb, pe & pick(cf[3:1], rp, 1'b0, ps[1]));
      chk("in_a", sa, pick(dt[7:5], rp, dw, ps[0]));
      chk("in_b", sbb, pick(dt[4:2], rp, dw, ps[0]));
      chk("main", mo, ps[0] & cf[7]);
      chk("types", {t1, t2}, mc[7:6]);
    end
    rchk("status", 12'h084, {26'h0, ps[3], rp, 2'h0});
    apb(1'b1, 12'h080, 32'h4);
    mm <= 1'b1;
    for (int k = 0; k < 13; k++) begin
      ia <= k % 3;
      ib <= (k + 1) % 3;
      // Opposite bits per edge, so a swapped edge always shows
      fr = 2'($random(seed));
      fb <= fr;
      rb <= ~fr;
      mc = (k == 12) ? 8'hC0 : {2'h3, 2'(k / 3), 2'(k % 3 + 1), 2'((k + 1) % 3 + 1)};
      apb(1'b1, 12'h04C, {24'h0, mc});
      repeat (20) @(posedge clk);
      seen = 4'h0;
      repeat (40) begin
        @(posedge clk);
        for (int c = 0; c < 4; c++) begin
          if (mv[c] === 1'b1) begin
            seen[c] = 1'b1;
            chk("mic_bit", md[c], micexp(c));
          end
        end
      end
      chk("mic_seen", seen, (k == 12) ? 4'h0 : 4'hF);
    end
    chk("clock_oe", doe, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk("pin_func", 12'h080, 32'h5);
    chk("clock_off", doe, 1'b0);
    rchk("route_a", 12'h044, 32'h80);
    tally_and_finish();
  end
endmodule : spr_route_bench
`default_nettype wire
